// File: core/agcatd_pkg.sv
// Constants, register layouts and time tables for the left AGC
// attack/decay timing configuration block.
// Assumes a 25 MHz core clock and an AGC that consumes times in ms.
package agcatd_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] AGCATD_OFS_SRDIV  = 8'h02;
    localparam logic [7:0] AGCATD_OFS_ATTACK = 8'h67;
    localparam logic [7:0] AGCATD_OFS_DECAY  = 8'h68;
    localparam logic [7:0] AGCATD_OFS_STATUS = 8'h70;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] AGCATD_RST_TIME   = 8'h00;
    localparam logic [7:0] AGCATD_RST_SRDIV  = 8'h00;
    localparam int         AGCATD_ST_MISM    = 0;
    localparam int         AGCATD_ST_ATKSEL  = 1;
    localparam int         AGCATD_ST_DECSEL  = 2;
    localparam int         AGCATD_ST_CLAMP   = 3;

    // Attack/decay register layout: D7 select, D6-D5 baseline,
    // D4-D2 power-of-two multiplier, D1-D0 reserved
    typedef struct packed {
        logic       sel;
        logic [1:0] base;
        logic [2:0] mult;
        logic [1:0] rsvd;
    } agcatd_time_s;

    // Sample-rate divider: upper nibble DAC ratio, lower nibble ADC ratio
    typedef struct packed {
        logic [3:0] dac_clock_divide_ratio;
        logic [3:0] adc_clock_divide_ratio;
    } agcatd_srdiv_s;

    // ----------------------------------------------------------------
    // Timing: one AGC update period, in ms
    // ----------------------------------------------------------------
    localparam int          AGCATD_CLK_HZ       = 25_000_000;
    localparam int          AGCATD_UPD_MS       = 1;
    localparam int          AGCATD_UPD_CYC      = AGCATD_CLK_HZ / 1000 * AGCATD_UPD_MS;
    localparam logic [15:0] AGCATD_NO_LIMIT     = 16'hFFFF;

    // Baseline attack: 7, 8, 10, 11 ms
    function automatic logic [8:0] agcatd_attack_base(input logic [1:0] code);
        case (code)
            2'h0:    agcatd_attack_base = 9'd7;
            2'h1:    agcatd_attack_base = 9'd8;
            2'h2:    agcatd_attack_base = 9'd10;
            default: agcatd_attack_base = 9'd11;
        endcase
    endfunction : agcatd_attack_base

    // Baseline decay: 50, 150, 250, 350 ms
    function automatic logic [8:0] agcatd_decay_base(input logic [1:0] code);
        case (code)
            2'h0:    agcatd_decay_base = 9'd50;
            2'h1:    agcatd_decay_base = 9'd150;
            2'h2:    agcatd_decay_base = 9'd250;
            default: agcatd_decay_base = 9'd350;
        endcase
    endfunction : agcatd_decay_base

    // Decay ceiling in ms; ratio code n means a divide ratio of 1 + n/2.
    // Codes past ratio 6 are undefined and keep the widest ceiling.
    function automatic logic [15:0] agcatd_decay_limit(input logic [3:0] code);
        case (code)
            4'h0:       agcatd_decay_limit = 16'd4000;
            4'h1:       agcatd_decay_limit = 16'd5600;
            4'h2:       agcatd_decay_limit = 16'd8000;
            4'h3:       agcatd_decay_limit = 16'd9600;
            4'h4, 4'h5: agcatd_decay_limit = 16'd11200;
            4'h6, 4'h7: agcatd_decay_limit = 16'd16000;
            4'h8:       agcatd_decay_limit = 16'd19200;
            default:    agcatd_decay_limit = 16'd22400;
        endcase
    endfunction : agcatd_decay_limit

endpackage : agcatd_pkg

// File: core/agcatd_time_calc.sv
// Baseline times power-of-two factor, with an upper clamp.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module agcatd_time_calc (
    input  wire logic [8:0]  base_ms,
    input  wire logic [2:0]  mult,
    input  wire logic [15:0] limit_ms,
    output logic      [15:0] time_ms,
    output logic             clamped
);
    // Widest product is 350 * 128 = 44800, which fits 16 bits
    wire logic [15:0] scaled_ms = {7'h00, base_ms} << mult;

    assign clamped = scaled_ms > limit_ms;
    assign time_ms = clamped ? limit_ms : scaled_ms;
endmodule : agcatd_time_calc

// File: core/agcatd_timing_cfg.sv
// Left AGC attack/decay time selection and scaling with register port.
// Assumes legacy times arrive in ms from logic on the same clock.
//
// Operation
// - Attack select 0 uses the legacy attack time, 1 uses the new attack fields.
// - Baseline attack codes 00..11 give 7, 8, 10 and 11 ms.
// - The attack multiplier code n scales the baseline by two to the n.
// - Decay select 0 uses the legacy decay time, 1 uses the new decay fields.
// - Baseline decay codes 00..11 give 50, 150, 250 and 350 ms.
// - The decay multiplier code n scales the baseline by two to the n.
// - Decay is clamped to 4, 5.6, 8, 9.6 s for ADC ratios 1, 1.5, 2, 2.5.
// - Decay is clamped to 11.2, 16, 19.2, 22.4 s for ratios 3-3.5, 4-4.5, 5, 5.5-6.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module agcatd_timing_cfg (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_q,
    input  wire logic [15:0] legacy_attack_ms,
    input  wire logic [15:0] legacy_decay_ms,
    output logic      [15:0] attack_periods_q,
    output logic      [15:0] decay_periods_q,
    output logic      [3:0]  adc_clock_divide_ratio_q,
    output logic             ratio_mismatch_q
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    agcatd_pkg::agcatd_time_s  atk_q;
    agcatd_pkg::agcatd_time_s  dec_q;
    agcatd_pkg::agcatd_srdiv_s srdiv_q;
    logic                      clamp_q;

    wire logic hit_atk   = reg_addr == agcatd_pkg::AGCATD_OFS_ATTACK;
    wire logic hit_dec   = reg_addr == agcatd_pkg::AGCATD_OFS_DECAY;
    wire logic hit_srdiv = reg_addr == agcatd_pkg::AGCATD_OFS_SRDIV;
    wire logic hit_stat  = reg_addr == agcatd_pkg::AGCATD_OFS_STATUS;

    // Reserved bits are stored as written; zeros are expected there
    always_ff @(posedge clk) begin
        if (srst) begin
            atk_q   <= agcatd_pkg::AGCATD_RST_TIME;
            dec_q   <= agcatd_pkg::AGCATD_RST_TIME;
            srdiv_q <= agcatd_pkg::AGCATD_RST_SRDIV;
        end else if (ce && reg_wr) begin
            if (hit_atk) atk_q <= reg_wdata;
            if (hit_dec) dec_q <= reg_wdata;
            if (hit_srdiv) srdiv_q <= reg_wdata;
        end
    end

    wire logic [7:0] status_w = {4'h0, clamp_q, dec_q.sel, atk_q.sel, ratio_mismatch_q};

    wire logic [7:0] rd_mux = hit_atk   ? atk_q   :
                              hit_dec   ? dec_q   :
                              hit_srdiv ? srdiv_q :
                              hit_stat  ? status_w : 8'h00;

    // Read data stands in the cycle after the strobe, and longer only while ce is low
    always_ff @(posedge clk) begin
        if (srst) reg_rdata_q <= 8'h00;
        else if (ce) reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end

    // ----------------------------------------------------------------
    // Time computation
    // ----------------------------------------------------------------
    logic [15:0] atk_new_ms;
    logic [15:0] dec_new_ms;
    logic        dec_clamped;

    agcatd_time_calc u_attack (
        .base_ms  (agcatd_pkg::agcatd_attack_base(atk_q.base)),
        .mult     (atk_q.mult),
        .limit_ms (agcatd_pkg::AGCATD_NO_LIMIT),
        .time_ms  (atk_new_ms),
        .clamped  ()
    );

    agcatd_time_calc u_decay (
        .base_ms  (agcatd_pkg::agcatd_decay_base(dec_q.base)),
        .mult     (dec_q.mult),
        .limit_ms (agcatd_pkg::agcatd_decay_limit(srdiv_q.adc_clock_divide_ratio)),
        .time_ms  (dec_new_ms),
        .clamped  (dec_clamped)
    );

    // Times are in ms and one update period is one ms, so no rescale
    wire logic [15:0] atk_sel_ms = atk_q.sel ? atk_new_ms : legacy_attack_ms;
    wire logic [15:0] dec_sel_ms = dec_q.sel ? dec_new_ms : legacy_decay_ms;
    // A mismatch is only reported; the ADC ratio alone sets the ceiling
    wire logic        mism_w     = srdiv_q.dac_clock_divide_ratio
                                   != srdiv_q.adc_clock_divide_ratio;

    always_ff @(posedge clk) begin
        if (srst) begin
            attack_periods_q         <= 16'h0000;
            decay_periods_q          <= 16'h0000;
            adc_clock_divide_ratio_q <= 4'h0;
            ratio_mismatch_q         <= 1'b0;
            clamp_q                  <= 1'b0;
        end else if (ce) begin
            attack_periods_q         <= atk_sel_ms;
            decay_periods_q          <= dec_sel_ms;
            adc_clock_divide_ratio_q <= srdiv_q.adc_clock_divide_ratio;
            ratio_mismatch_q         <= mism_w;
            clamp_q                  <= dec_q.sel & dec_clamped;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_atk_write;
        ce && reg_wr && hit_atk;
    endsequence

    sequence s_dec_write;
        ce && reg_wr && hit_dec;
    endsequence

    attack_src_a: assert property (ce && !atk_q.sel |=>
        attack_periods_q == $past(legacy_attack_ms))
        else $error("legacy attack time not passed through");

    attack_base_a: assert property (s_atk_write ##1 ce && atk_q.sel ##1 1'b1
        |-> attack_periods_q == ({7'h00, agcatd_pkg::agcatd_attack_base($past(atk_q.base))}
            << $past(atk_q.mult)))
        else $error("attack time not baseline times factor");

    attack_max_a: assert property (ce && atk_q == 8'hFC |=> attack_periods_q == 16'd1408)
        else $error("largest attack time wrong");

    decay_src_a: assert property (ce && !dec_q.sel |=>
        decay_periods_q == $past(legacy_decay_ms))
        else $error("legacy decay time not passed through");

    decay_base_a: assert property (ce && dec_q == 8'hA8 |=> decay_periods_q == 16'd600)
        else $error("decay baseline wrong");

    decay_mult_a: assert property (ce && dec_q == 8'h88 && srdiv_q[3:0] == 4'h0
        |=> decay_periods_q == 16'd200)
        else $error("decay factor wrong");

    decay_clamp_a: assert property (s_dec_write ##1 ce && dec_q.sel ##1 1'b1
        |-> decay_periods_q <= agcatd_pkg::agcatd_decay_limit($past(srdiv_q[3:0], 1)))
        else $error("decay time above ceiling");

    decay_ceiling_a: assert property (ce && dec_q == 8'hFC && srdiv_q[3:0] == 4'h8
        |=> decay_periods_q == 16'd19200 && $past(dec_clamped))
        else $error("decay not clamped at ratio 5");

    period_track_a: assert property (ce ##1 ce && $stable(atk_sel_ms)
        |=> attack_periods_q == $past(atk_sel_ms, 2))
        else $error("attack output stale");

    reset_legacy_a: assert property ($past(srst) |-> !atk_q.sel && !dec_q.sel)
        else $error("select bits not cleared by reset");

    // ----------------------------------------------------------------
    // Read port, clock enable and status assertions
    // ----------------------------------------------------------------
    // Software may read back to back, so with ce high an answer must never linger a cycle
    sequence s_rd_req;
        ce && reg_rd;
    endsequence

    sequence s_atk_read;
        s_rd_req ##0 hit_atk ##1 1'b1;
    endsequence

    // New decay fields selected with a product above the ceiling
    sequence s_dec_over;
        ce && dec_q.sel && dec_clamped;
    endsequence

    rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data standing without a read");

    read_back_a: assert property (s_atk_read |-> reg_rdata_q == $past(atk_q))
        else $error("attack register read back wrong");

    status_read_a: assert property (s_rd_req ##0 hit_stat ##1 1'b1
        |-> reg_rdata_q[2:1] == {$past(dec_q.sel), $past(atk_q.sel)})
        else $error("select bits misreported in status");

    // Reset still wins over a low enable, so the check is disabled there
    enable_freeze_a: assert property (!ce |=> $stable(atk_q) && $stable(dec_q)
        && $stable(srdiv_q) && $stable(reg_rdata_q) && $stable(attack_periods_q)
        && $stable(decay_periods_q))
        else $error("state moved while the clock enable was low");

    decay_limit_a: assert property (ce && dec_q.sel |=>
        decay_periods_q <= agcatd_pkg::agcatd_decay_limit($past(srdiv_q[3:0])))
        else $error("decay time above the ceiling of its divide ratio");

    clamp_status_a: assert property (s_dec_over |=>
        clamp_q && decay_periods_q == agcatd_pkg::agcatd_decay_limit($past(srdiv_q[3:0])))
        else $error("clamped decay not at the ceiling or not flagged");

    legacy_unclamped_a: assert property (ce && !dec_q.sel |=> !clamp_q)
        else $error("legacy decay flagged as clamped");

    // The ceiling follows the ADC nibble only; a differing DAC nibble is just reported
    ratio_flag_a: assert property (ce |=> ratio_mismatch_q ==
        ($past(srdiv_q.dac_clock_divide_ratio) != $past(srdiv_q.adc_clock_divide_ratio)))
        else $error("divide ratio mismatch flag wrong");

    ratio_out_a: assert property (ce |=> adc_clock_divide_ratio_q == $past(srdiv_q[3:0]))
        else $error("divide ratio output stale");

endmodule : agcatd_timing_cfg

// File: testbench/test_agcatd_timing_cfg.sv
// Self-checking bench for the left AGC attack/decay timing block.
// Assumes the register port of agcatd_timing_cfg; assertions live in the design.
`timescale 1ns/10ps
module test_agcatd_timing_cfg;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata_q;
    logic [15:0] legacy_attack_ms = 16'h0123;
    // Legacy decay sits above the ratio 2 ceiling, so a wrong clamp would show
    logic [15:0] legacy_decay_ms = 16'h4E20;
    logic [15:0] attack_periods_q;
    logic [15:0] decay_periods_q;
    logic [3:0]  adc_clock_divide_ratio_q;
    logic        ratio_mismatch_q;
    int          bad_count = 0;
    int          comparisons = 0;
    int          lim [16] = '{4000, 5600, 8000, 9600, 11200, 11200, 16000, 16000, 19200,
                              22400, 22400, 22400, 22400, 22400, 22400, 22400};
    int          atk [4] = '{7, 8, 10, 11};
    int          dec [4] = '{50, 150, 250, 350};
    int          e;

    always #20 clk = ~clk;

    agcatd_timing_cfg i_dut (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .legacy_attack_ms(legacy_attack_ms), .legacy_decay_ms(legacy_decay_ms),
        .attack_periods_q(attack_periods_q), .decay_periods_q(decay_periods_q),
        .adc_clock_divide_ratio_q(adc_clock_divide_ratio_q),
        .ratio_mismatch_q(ratio_mismatch_q));

    // ----------------------------------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Outputs follow a write one edge after the register takes it
    task automatic settle();
        @(posedge clk);
        #1;
    endtask : settle

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk("rdata", {8'h00, exp}, {8'h00, reg_rdata_q});
        @(posedge clk);
        #1;
        chk("rdata idle", 16'h0000, {8'h00, reg_rdata_q});
    endtask : rd_chk

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        settle();
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h67, 8'h00);
        rd_chk(8'h68, 8'h00);
        chk("attack", legacy_attack_ms, attack_periods_q);
        chk("decay", legacy_decay_ms, decay_periods_q);
        // Every baseline with the smallest and largest factor, back to back
        for (int b = 0; b < 4; b++) begin
            for (int m = 0; m < 8; m += 7) begin
                wr(8'h67, {1'b1, b[1:0], m[2:0], 2'b00});
                settle();
                chk("attack", 16'(atk[b] << m), attack_periods_q);
            end
        end
        for (int m = 1; m < 7; m++) begin
            wr(8'h67, {1'b1, 2'b01, m[2:0], 2'b00});
            settle();
            chk("attack", 16'(8 << m), attack_periods_q);
        end
        rd_chk(8'h67, 8'hB8);
        wr(8'h67, 8'h78);
        settle();
        chk("attack", legacy_attack_ms, attack_periods_q);
        // Decay at every baseline, small factor, never reaching the ceiling
        for (int b = 0; b < 4; b++) begin
            wr(8'h68, {1'b1, b[1:0], 3'h2, 2'b00});
            settle();
            chk("decay", 16'(dec[b] * 4), decay_periods_q);
        end
        // Largest decay against the ceiling of each divide ratio code
        wr(8'h68, 8'hFC);
        for (int n = 0; n < 16; n++) begin
            wr(8'h02, {n[3:0], n[3:0]});
            settle();
            e = (44800 < lim[n]) ? 44800 : lim[n];
            chk("decay", 16'(e), decay_periods_q);
            chk("ratio", {12'h000, n[3:0]}, {12'h000, adc_clock_divide_ratio_q});
            chk("mismatch", 16'h0000, {15'h0000, ratio_mismatch_q});
        end
        // 250 ms times 16 is exactly 4 s at ratio 1
        wr(8'h02, 8'h00);
        wr(8'h68, 8'hD0);
        settle();
        chk("decay", 16'd4000, decay_periods_q);
        wr(8'h68, 8'hF8);
        settle();
        chk("decay", 16'd4000, decay_periods_q);
        rd_chk(8'h70, 8'h0C);
        wr(8'h02, 8'h12);
        settle();
        chk("mismatch", 16'h0001, {15'h0000, ratio_mismatch_q});
        chk("ratio", 16'h0002, {12'h000, adc_clock_divide_ratio_q});
        chk("decay", 16'd8000, decay_periods_q);
        // Legacy decay is not clamped; unmapped places read zero and ignore writes
        wr(8'h68, 8'h7C);
        settle();
        chk("decay", legacy_decay_ms, decay_periods_q);
        wr(8'h55, 8'hA5);
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h02, 8'h12);
        rd_chk(8'h68, 8'h7C);
        rd_chk(8'h70, 8'h01);
        // Clock enable low: writes are dropped and outputs hold their last value
        @(posedge clk);
        ce               <= 1'b0;
        legacy_attack_ms <= 16'h0456;
        wr(8'h67, 8'hFC);
        settle();
        chk("frozen attack", 16'h0123, attack_periods_q);
        @(posedge clk);
        ce <= 1'b1;
        settle();
        chk("attack", 16'h0456, attack_periods_q);
        rd_chk(8'h67, 8'h78);
        // Reset in mid-run sends both times back to the legacy source
        wr(8'h67, 8'hFC);
        wr(8'h68, 8'hFC);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("attack in reset", 16'h0000, attack_periods_q);
        settle();
        chk("attack", legacy_attack_ms, attack_periods_q);
        chk("decay", legacy_decay_ms, decay_periods_q);
        rd_chk(8'h67, 8'h00);
        rd_chk(8'h68, 8'h00);
        rd_chk(8'h70, 8'h00);
        close_out();
    end

    // Whole sequence needs well under 1000 cycles
    initial begin
        #(40 * 5000);
        bad_count++;
        close_out();
    end
endmodule : test_agcatd_timing_cfg
